/* fixed_priority_interrupt_unit.sv */
// fixed priority interrupt unit with axi4-lite register access
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
module fixed_priority_interrupt_unit
    import irq_unit_pkg::*;
#(
    parameter int N1 = 4,
    parameter int N2 = 4,
    parameter int N3 = 2,
    parameter int N4 = 2,
    parameter bit EMULATE_ANOMALY = 1'b1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // request lines, active low except src2_line, whose polarity is selectable
    input wire logic nmi_n,
    input wire logic [N1-1:0] src1_n,
    input wire logic [N2-1:0] src2_line,
    input wire logic [N3-1:0] src3_n,
    input wire logic [N4-1:0] src4_n,
    // core sequencer
    input wire logic instr_end,
    input wire logic irq_ack,
    input wire logic return_from_irq,
    input wire logic opt_zero_window,
    input wire logic core_sleeping,
    output logic irq_valid,
    output logic [2:0] irq_src,
    output logic [11:0] irq_vector,
    output logic pc_push,
    output logic pc_pop,
    output logic wake,
    output logic [1:0] context_out,
    // flag sets
    input wire logic flag_we,
    input wire logic carry_in,
    input wire logic zero_in,
    output logic carry_out,
    output logic zero_out,
    // axi4-lite slave
    input wire logic [11:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [11:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    localparam int NE = N1 + N2 + N3 + N4;

    function automatic logic [11:0] vec_of(input logic [2:0] s);
        logic [11:0] v;
        v = VEC_SRC0;
        unique case (s)
            3'd1: v = VEC_SRC1;
            3'd2: v = VEC_SRC2;
            3'd3: v = VEC_SRC3;
            3'd4: v = VEC_SRC4;
            default: v = VEC_SRC0;
        endcase
        return v;
    endfunction

    logic [7:0] opt_q;
    logic nmi_prev_q, src1_prev_q, src2_prev_q;
    logic nmi_latch_q, src1_latch_q, src2_latch_q;
    logic irq_valid_q;
    logic [2:0] irq_src_q;
    logic [11:0] irq_vector_q;
    logic pc_push_q, pc_pop_q;
    ctx_t ctx_q, nmi_ret_q;
    logic [1:0] bank_q, nmi_bank_q;
    logic [2:0] carry_q, zero_q;
    logic [NE-1:0] evt_q;
    logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    // option fields
    wire gen = opt_q[OPT_GEN_BIT];
    wire level1 = opt_q[OPT_LEVEL_BIT];
    wire pol2 = opt_q[OPT_POL_BIT];

    // or of events per source
    wire line1 = ~&src1_n;
    wire line2r = |src2_line;
    wire line2f = ~&src2_line;
    wire line3 = ~&src3_n;
    wire line4 = ~&src4_n;
    wire nmi = ~nmi_n;
    wire src2_cur = pol2 ? line2r : line2f;
    wire src2_prv = src2_prev_q;

    // edge detection
    wire nmi_edge = nmi & ~nmi_prev_q;
    wire src1_edge = line1 & ~src1_prev_q;
    wire src2_edge = src2_cur & ~src2_prv;

    // entry acknowledge decode
    wire ack = irq_ack & irq_valid_q;
    wire clr0 = ack & (irq_src_q == 3'd0);
    wire clr1 = ack & (irq_src_q == 3'd1);
    wire clr2 = ack & (irq_src_q == 3'd2);

    // requests as seen at an instruction end
    wire req1 = level1 ? line1 : src1_latch_q;
    wire req2 = src2_latch_q;
    wire req3 = line3;
    wire req4 = line4;
    wire mask_ok = gen & (ctx_q == CTX_NORMAL);
    wire nmi_ok = nmi_latch_q & (ctx_q != CTX_NMI);
    wire any_mask = mask_ok & (req1 | req2 | req3 | req4);
    wire [2:0] pick = nmi_ok ? 3'd0 : req1 ? 3'd1 : req2 ? 3'd2 : req3 ? 3'd3 : 3'd4;
    wire post = instr_end & ~irq_valid_q & (nmi_ok | any_mask);

    // wake needs global enable
    wire wake_c = core_sleeping & gen & (nmi_latch_q | req1 | req2 | req3 | req4);

    // flag bank on entry
    wire keep_normal = EMULATE_ANOMALY & opt_zero_window & (irq_src_q != 3'd0);
    wire [1:0] entry_bank = (irq_src_q == 3'd0) ? 2'd2 : keep_normal ? bank_q : 2'd1;

    // event flag capture
    wire [NE-1:0] evt_now = {~src4_n, ~src3_n, pol2 ? src2_line : ~src2_line, ~src1_n};

    // axi decode
    wire aw_take = s_awvalid & s_awready;
    wire w_take = s_wvalid & s_wready;
    wire aw_have = aw_got_q | aw_take;
    wire w_have = w_got_q | w_take;
    wire [11:0] wa = aw_got_q ? awaddr_q : s_awaddr;
    wire [31:0] wd = w_got_q ? wdata_q : s_wdata;
    wire [3:0] ws = w_got_q ? wstrb_q : s_wstrb;
    wire do_write = aw_have & w_have & ~bvalid_q;
    wire wr_opt = do_write & (wa == ADDR_OPTIONS) & ws[0];
    wire wr_evt = do_write & (wa == ADDR_EVENTS);
    wire wa_ok = (wa == ADDR_OPTIONS) | (wa == ADDR_EVENTS) | (wa == ADDR_STATE);
    wire ar_take = s_arvalid & s_arready;
    wire [31:0] state_word = {22'h00_0000, ctx_q, irq_src_q, irq_valid_q,
                             src2_latch_q, src1_latch_q, nmi_latch_q, gen};
    wire [31:0] evt_word = 32'(evt_q);
    wire ra_ok = (s_araddr == ADDR_OPTIONS) | (s_araddr == ADDR_EVENTS)
                 | (s_araddr == ADDR_STATE);
    wire [31:0] rd_c = (s_araddr == ADDR_EVENTS) ? evt_word :
                       (s_araddr == ADDR_STATE) ? state_word : 32'h0000_0000;
    wire [NE-1:0] evt_clr = wr_evt ? wd[NE-1:0] : '0;

    assign s_awready = ~aw_got_q & ~bvalid_q;
    assign s_wready = ~w_got_q & ~bvalid_q;
    assign s_bvalid = bvalid_q;
    assign s_bresp = bresp_q;
    assign s_arready = ~rvalid_q;
    assign s_rvalid = rvalid_q;
    assign s_rdata = rdata_q;
    assign s_rresp = rresp_q;
    assign irq_valid = irq_valid_q;
    assign irq_src = irq_src_q;
    assign irq_vector = irq_vector_q;
    assign pc_push = pc_push_q;
    assign pc_pop = pc_pop_q;
    assign wake = wake_c;
    assign context_out = ctx_q;
    assign carry_out = carry_q[bank_q];
    assign zero_out = zero_q[bank_q];

    // options register, write only
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            opt_q <= OPT_RESET;
        end else if (wr_opt) begin
            opt_q <= wd[7:0] & 8'h70;
        end
    end

    // previous line levels
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            nmi_prev_q <= 1'b0;
            src1_prev_q <= 1'b0;
            src2_prev_q <= 1'b0;
        end else begin
            nmi_prev_q <= nmi;
            src1_prev_q <= line1;
            src2_prev_q <= src2_cur;
        end
    end

    // request latches, set wins over clear
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            nmi_latch_q <= 1'b0;
            src1_latch_q <= 1'b0;
            src2_latch_q <= 1'b0;
        end else begin
            nmi_latch_q <= nmi_edge | (nmi_latch_q & ~clr0);
            src1_latch_q <= ~level1 & (src1_edge | (src1_latch_q & ~clr1));
            src2_latch_q <= src2_edge | (src2_latch_q & ~clr2);
        end
    end

    // request to core
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq_valid_q <= 1'b0;
            irq_src_q <= 3'd0;
            irq_vector_q <= VEC_SRC0;
        end else if (post) begin
            irq_valid_q <= 1'b1;
            irq_src_q <= pick;
            irq_vector_q <= vec_of(pick);
        end else if (ack) begin
            irq_valid_q <= 1'b0;
        end
    end

    // context, stack strobes and flag bank
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctx_q <= CTX_NORMAL;
            nmi_ret_q <= CTX_NORMAL;
            bank_q <= 2'd0;
            nmi_bank_q <= 2'd0;
            pc_push_q <= 1'b0;
            pc_pop_q <= 1'b0;
        end else begin
            pc_push_q <= ack;
            pc_pop_q <= return_from_irq & (ctx_q != CTX_NORMAL);
            if (ack) begin
                bank_q <= entry_bank;
                if (irq_src_q == 3'd0) begin
                    ctx_q <= CTX_NMI;
                    nmi_ret_q <= ctx_q;
                    nmi_bank_q <= bank_q;
                end else begin
                    ctx_q <= CTX_IRQ;
                end
            end else if (return_from_irq) begin
                if (ctx_q == CTX_NMI) begin
                    ctx_q <= nmi_ret_q;
                    bank_q <= nmi_bank_q;
                end else begin
                    ctx_q <= CTX_NORMAL;
                    bank_q <= 2'd0;
                end
            end
        end
    end

    // three carry and zero sets
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            carry_q <= 3'b000;
            zero_q <= 3'b000;
        end else if (flag_we) begin
            carry_q[bank_q] <= carry_in;
            zero_q[bank_q] <= zero_in;
        end
    end

    // event flags, write one to clear, set wins
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            evt_q <= '0;
        end else begin
            evt_q <= evt_now | (evt_q & ~evt_clr);
        end
    end

    // axi write channel
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                awaddr_q <= s_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_wdata;
                wstrb_q <= s_wstrb;
            end
            if (do_write) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wa_ok ? RESP_OKAY : RESP_DECERR;
            end else begin
                aw_got_q <= aw_have;
                w_got_q <= w_have;
                if (s_bready) begin
                    bvalid_q <= 1'b0;
                end
            end
        end
    end

    // axi read channel
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_c;
            rresp_q <= ra_ok ? RESP_OKAY : RESP_DECERR;
        end else if (s_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    property p_vector;
        irq_valid_q |-> irq_vector_q == vec_of(irq_src_q);
    endproperty
    a_vector: assert property (p_vector) else $error("vector mismatch");

    property p_gen_gate;
        $rose(irq_valid_q) && irq_src_q != 3'd0 |-> $past(gen);
    endproperty
    a_gen_gate: assert property (p_gen_gate) else $error("masked request posted");

    property p_nmi_first;
        instr_end && nmi_latch_q && !irq_valid_q && ctx_q != CTX_NMI
            |=> irq_valid_q && irq_src_q == 3'd0;
    endproperty
    a_nmi_first: assert property (p_nmi_first) else $error("nmi not first");

    property p_no_nest;
        $rose(irq_valid_q) && irq_src_q != 3'd0 |-> $past(ctx_q) == CTX_NORMAL;
    endproperty
    a_no_nest: assert property (p_no_nest) else $error("maskable nested");

    property p_prio;
        $rose(irq_valid_q) && irq_src_q == 3'd2 |-> !$past(req1);
    endproperty
    a_prio: assert property (p_prio) else $error("priority order broken");

    property p_latch_hold;
        src2_latch_q && !clr2 |=> src2_latch_q;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("edge latch lost");

    property p_wake;
        wake |-> gen && core_sleeping;
    endproperty
    a_wake: assert property (p_wake) else $error("wake without enable");

    property p_entry;
        ack |=> pc_push_q && ctx_q != CTX_NORMAL && !irq_valid_q;
    endproperty
    a_entry: assert property (p_entry) else $error("entry sequence wrong");

    property p_return_from_irq;
        return_from_irq && !ack && ctx_q == CTX_IRQ |=> ctx_q == CTX_NORMAL && pc_pop_q && bank_q == 2'd0;
    endproperty
    a_return_from_irq: assert property (p_return_from_irq) else $error("return wrong");

    property p_opt_reset;
        $rose(resetn) |-> opt_q == OPT_RESET;
    endproperty
    a_opt_reset: assert property (p_opt_reset) else $error("options not cleared");
endmodule

/* irq_unit_pkg.sv */
// constants and types of the fixed priority interrupt unit
// Notes on behaviour
// - four maskable sources plus one top priority non-maskable source, each with a vector
// - an accepted request loads the program counter with its vector address
// - vectors fixed: 0 FFC, 1 FF6, 2 FF4, 3 FF2, 4 FF0 in program space
// - non-maskable preempts any maskable routine but not its own; maskable routines never preempt each other
// - pending maskable requests served in fixed order, source 1 highest
// - events are ORed per source, each keeping its own readable flag
// - global enable low blocks maskable sources only; high enables all
// - enable low lets non-maskable run but never wakes the core from stop or wait
// - non-maskable request latched, cleared when its routine begins
// - source 1 level sensitive when selected, otherwise falling edge
// - source 2 always edge sensitive, polarity bit selects rising or falling
// - sources 3 and 4 are level sensitive only
// - edge latch set on edge, cleared at routine start, only one held
// - level requests not stored; low level counts only when sampled at instruction end
// - lines tested at each instruction end; a request replaces the next instruction
// - entry swaps flags, pushes pc, inhibits maskable lines, clears latch, loads vector
// - separate carry and zero sets for normal, interrupt and non-maskable contexts
// - return restores previous flag set and pops the saved program counter
// - maskable entry during zero write of options keeps the normal flag pair
// - options register write only, no bit operations, zero after reset
// - options bit 6 source 1 level, bit 5 source 2 polarity, bit 4 enable
package irq_unit_pkg;
    localparam logic [11:0] VEC_SRC0 = 12'hFFC;
    localparam logic [11:0] VEC_SRC1 = 12'hFF6;
    localparam logic [11:0] VEC_SRC2 = 12'hFF4;
    localparam logic [11:0] VEC_SRC3 = 12'hFF2;
    localparam logic [11:0] VEC_SRC4 = 12'hFF0;
    localparam logic [7:0] OPT_RESET = 8'h00;
    localparam int OPT_LEVEL_BIT = 6;
    localparam int OPT_POL_BIT = 5;
    localparam int OPT_GEN_BIT = 4;
    localparam logic [11:0] ADDR_OPTIONS = 12'h000;
    localparam logic [11:0] ADDR_EVENTS = 12'h004;
    localparam logic [11:0] ADDR_STATE = 12'h008;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;
    typedef enum logic [1:0] {CTX_NORMAL, CTX_IRQ, CTX_NMI} ctx_t;
endpackage

/* core_seq_model.sv */
// core sequencer model: instruction ends, entry acks and returns
`timescale 1ns/100ps
module core_seq_model (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // unit side
    input wire logic irq_valid,
    input wire logic [2:0] irq_src,
    input wire logic [11:0] irq_vector,
    output logic instr_end,
    output logic irq_ack,
    output logic return_from_irq,
    // bench side
    input wire logic [2:0] lag,
    output int acks,
    output int depth,
    output logic [2:0] last_src,
    output logic [11:0] last_vec
);
    logic [7:0] tick_q;
    logic [2:0] wait_q;
    logic [4:0] left_q;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tick_q <= 8'h00;
            wait_q <= 3'h0;
            left_q <= 5'h00;
            instr_end <= 1'b0;
            irq_ack <= 1'b0;
            return_from_irq <= 1'b0;
            acks <= 0;
            depth <= 0;
            last_src <= 3'h0;
            last_vec <= 12'h000;
        end else begin
            tick_q <= tick_q + 8'h01;
            instr_end <= (tick_q[1:0] == 2'b11);
            irq_ack <= 1'b0;
            return_from_irq <= 1'b0;
            if (irq_valid && !irq_ack) begin
                if (wait_q >= lag) begin
                    irq_ack <= 1'b1;
                    wait_q <= 3'h0;
                end else begin
                    wait_q <= wait_q + 3'h1;
                end
            end
            if (irq_ack) begin
                acks <= acks + 1;
                depth <= depth + 1;
                last_src <= irq_src;
                last_vec <= irq_vector;
                left_q <= 5'd20;
            end else if (left_q == 5'd1) begin
                return_from_irq <= 1'b1;
                depth <= depth - 1;
                left_q <= (depth > 1) ? 5'd20 : 5'd0;
            end else if (left_q != 5'd0) begin
                left_q <= left_q - 5'd1;
            end
        end
    end
endmodule

/* fixed_priority_interrupt_unit_tb_top.sv */
// self-checking bench of the fixed priority interrupt unit
`timescale 1ns/100ps
module fixed_priority_interrupt_unit_tb_top;
    import irq_unit_pkg::*;
    logic mclk, resetn, nmi_n, instr_end, irq_ack, return_from_irq, opt_zero_window, core_sleeping;
    logic [3:0] src1_n, src2_line, s_wstrb;
    logic [1:0] src3_n, src4_n, context_out, s_bresp, s_rresp, rr;
    logic irq_valid, pc_push, pc_pop, wake, flag_we, carry_in, zero_in, carry_out, zero_out;
    logic [2:0] irq_src, lag, last_src;
    logic [11:0] irq_vector, last_vec, s_awaddr, s_araddr;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    logic [31:0] s_wdata, s_rdata, rd;
    int acks, depth, k;
    int bad_count = 0;
    int samples_checked = 0;
    int pushes = 0;
    int pops = 0;
    always @(posedge mclk) begin
        if (pc_push) begin
            pushes++;
        end
        if (pc_pop) begin
            pops++;
        end
    end
    fixed_priority_interrupt_unit fixed_priority_interrupt_unit_i (
        .mclk, .resetn, .nmi_n, .src1_n, .src2_line, .src3_n, .src4_n, .instr_end,
        .irq_ack, .return_from_irq, .opt_zero_window, .core_sleeping, .irq_valid, .irq_src,
        .irq_vector, .pc_push, .pc_pop, .wake, .context_out, .flag_we, .carry_in,
        .zero_in, .carry_out, .zero_out, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
        .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
        .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
    core_seq_model core_seq_model_i (.mclk, .resetn, .irq_valid, .irq_src, .irq_vector,
        .instr_end, .irq_ack, .return_from_irq, .lag, .acks, .depth, .last_src, .last_vec);
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [11:0] vec_of(input int s);
        case (s)
            0: return 12'hFFC;
            1: return 12'hFF6;
            2: return 12'hFF4;
            3: return 12'hFF2;
            default: return 12'hFF0;
        endcase
    endfunction
    task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw, w;
        int n;
        aw = 1;
        w = 1;
        n = 0;
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (n < 50) begin
            @(posedge mclk);
            n++;
            if (s_bvalid && !aw && !w) break;
            if (aw && s_awready) begin
                aw = 0;
                s_awvalid <= 1'b0;
            end
            if (w && s_wready) begin
                w = 0;
                s_wvalid <= 1'b0;
            end
        end
        r = s_bresp;
        s_bready <= 1'b0;
        @(posedge mclk);
        chk("write wait", n < 50, 1);
    endtask
    task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ar;
        int n;
        ar = 1;
        n = 0;
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        while (n < 50) begin
            @(posedge mclk);
            n++;
            if (ar && s_arready) begin
                ar = 0;
                s_arvalid <= 1'b0;
            end else if (!ar && s_rvalid) break;
        end
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
        @(posedge mclk);
        chk("read wait", n < 50, 1);
    endtask
    task automatic expect_irq(input int s);
        int n, a0;
        a0 = acks;
        n = 0;
        while (acks == a0 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        chk("source", {29'h0, last_src}, s);
        chk("vector", {20'h0, last_vec}, {20'h0, vec_of(s)});
    endtask
    task automatic quiet(input int n);
        int a0;
        a0 = acks;
        repeat (n) @(posedge mclk);
        chk("no entry", acks, a0);
    endtask
    task automatic settle();
        int n;
        n = 0;
        while (depth != 0 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        repeat (4) @(posedge mclk);
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        wrap_up();
    end
    initial begin
        resetn = 1'b0;
        nmi_n = 1'b1;
        src1_n = 4'hF;
        src2_line = 4'hF;
        src3_n = 2'h3;
        src4_n = 2'h3;
        opt_zero_window = 1'b0;
        core_sleeping = 1'b0;
        flag_we = 1'b0;
        carry_in = 1'b0;
        zero_in = 1'b0;
        lag = 3'h0;
        {s_awaddr, s_araddr, s_wdata} = '0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        s_wstrb = 4'hF;
        k = $urandom(32'hf31f);
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        axr(12'h000, rd, rr);
        chk("options read", rd, 0);
        axr(12'h008, rd, rr);
        chk("state after reset", rd, 0);
        axr(12'h00C, rd, rr);
        chk("unmapped resp", rr, 2'b11);
        core_sleeping <= 1'b1;
        src3_n <= 2'b10;
        nmi_n <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("wake", wake, 0);
        expect_irq(0);
        nmi_n <= 1'b1;
        settle();
        quiet(40);
        src3_n <= 2'h3;
        core_sleeping <= 1'b0;
        axw(12'h000, 32'h0000_0010, rr);
        chk("write resp", rr, 2'b00);
        quiet(30);
        lag <= 3'($urandom % 4);
        k = $urandom % 4;
        src1_n <= ~(4'h1 << k);
        @(posedge mclk);
        src4_n <= 2'b01;
        expect_irq(1);
        quiet(10);
        expect_irq(4);
        src4_n <= 2'h3;
        settle();
        quiet(30);
        axw(12'h000, 32'h0000_0050, rr);
        expect_irq(1);
        src1_n <= 4'hF;
        settle();
        axw(12'h000, 32'h0000_0010, rr);
        lag <= 3'h7;
        repeat (3) begin
            src2_line <= ~(4'h1 << ($urandom % 4));
            @(posedge mclk);
            src2_line <= 4'hF;
            @(posedge mclk);
        end
        expect_irq(2);
        settle();
        quiet(30);
        lag <= 3'($urandom % 4);
        src2_line <= 4'h0;
        expect_irq(2);
        settle();
        axw(12'h000, 32'h0000_0030, rr);
        src2_line <= 4'h1 << ($urandom % 4);
        expect_irq(2);
        src2_line <= 4'h0;
        settle();
        axw(12'h004, 32'h0000_0FFF, rr);
        flag_we <= 1'b1;
        carry_in <= 1'b1;
        zero_in <= 1'b1;
        @(posedge mclk);
        flag_we <= 1'b0;
        @(posedge mclk);
        chk("normal flags", {carry_out, zero_out}, 2'b11);
        k = $urandom % 2;
        src3_n <= ~(2'h1 << k);
        core_sleeping <= 1'b1;
        expect_irq(3);
        chk("wake", wake, 1);
        chk("irq context", context_out, 2'b01);
        chk("irq flags", {carry_out, zero_out}, 2'b00);
        axr(12'h004, rd, rr);
        chk("event flag", rd[9:8], 2'h1 << k);
        src3_n <= 2'h3;
        core_sleeping <= 1'b0;
        nmi_n <= 1'b0;
        expect_irq(0);
        chk("nmi context", context_out, 2'b10);
        nmi_n <= 1'b1;
        settle();
        chk("normal context", context_out, 2'b00);
        chk("restored flags", {carry_out, zero_out}, 2'b11);
        opt_zero_window <= 1'b1;
        src4_n <= 2'b10;
        expect_irq(4);
        chk("anomaly context", context_out, 2'b01);
        chk("anomaly flags", {carry_out, zero_out}, 2'b11);
        src4_n <= 2'h3;
        opt_zero_window <= 1'b0;
        settle();
        axw(12'h004, 32'h0000_0FFF, rr);
        axr(12'h004, rd, rr);
        chk("events cleared", rd, 0);
        chk("pc pushes", pushes, acks);
        chk("pc pops", pops, acks);
        wrap_up();
    end
endmodule
